// ==== erdma_dev.sv ====
// receive descriptor dma engine: switch frame stream into host buffers
`timescale 1ns/100ps
`default_nettype none
module erdma_dev (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // frame stream from the switch port
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic [2:0] i_rx_nbytes,
  input wire logic i_rx_crc_err,
  input wire logic i_rx_phy_err,
  input wire logic i_rx_runt,
  input wire logic i_rx_mcast,
  input wire logic i_rx_ip_err,
  input wire logic i_rx_tcp_err,
  input wire logic i_rx_udp_err,
  input wire logic [15:0] i_rx_type_len,
  output logic o_rx_ready,
  // events and state
  output logic o_frame_done,
  output logic o_frame_dropped,
  output logic o_busy,
  // host side
  erdma_if.dev bus
);
  typedef enum logic [3:0] {
    S_IDLE, S_RD0, S_RD1, S_RD2, S_RD3, S_DATA, S_WRD, S_DRAIN, S_CLOSE
  } erdma_dev_st_e;

  typedef struct packed {
    erdma_dev_st_e st;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] cur;
    logic [31:0] buf_a;
    logic [31:0] nxt;
    logic [10:0] size;
    logic [11:0] off;
    logic ring_end;
    logic [15:0] len;
    logic first;
    logic last;
    logic phy;
    logic crc;
    logic runt;
    logic mc;
    logic ip_bad;
    logic tcp_bad;
    logic udp_bad;
    logic ftype;
    logic done;
    logic drop;
  } erdma_dev_s;

  erdma_dev_s r;
  erdma_dev_s n;
  logic long_w;
  logic [31:0] stat_w;

  // status word handed back with the descriptor
  always_comb begin
    long_w = r.len > erdma_pkg::MAX_FRAME_LEN;
    stat_w = 32'h0000_0000; // owner cleared on hand-back
    stat_w[erdma_pkg::FIRST_BIT] = r.first;
    stat_w[erdma_pkg::LAST_BIT] = r.last;
    // frame-level flags except the phy error only carried on the last descriptor
    stat_w[erdma_pkg::IP_SUM_BIT] = r.last & r.ip_bad;
    stat_w[erdma_pkg::TCP_SUM_BIT] = r.last & r.tcp_bad;
    stat_w[erdma_pkg::UDP_SUM_BIT] = r.last & r.udp_bad;
    stat_w[erdma_pkg::ERRS_BIT] = r.last & (r.crc | long_w | r.runt);
    stat_w[erdma_pkg::MCAST_BIT] = r.last & r.mc;
    stat_w[erdma_pkg::PHYERR_BIT] = r.phy;
    stat_w[erdma_pkg::LONG_BIT] = r.last & long_w;
    stat_w[erdma_pkg::RUNT_BIT] = r.last & r.runt;
    stat_w[erdma_pkg::CRC_BIT] = r.last & r.crc;
    stat_w[erdma_pkg::FTYPE_BIT] = r.last & ~r.runt & r.ftype;
    stat_w[erdma_pkg::LEN_MSB:0] = r.last ? r.len[10:0] : 11'h000;
  end

  // next state: descriptor walk, data writes and hand-back
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.drop = 1'b0;
    unique case (r.st)
      S_IDLE: begin
        // bases must be loaded by software first
        if (bus.run && bus.bases_ok) begin
          n.cur = bus.rx_base;
          n.st = S_RD0;
        end
      end
      S_RD0: begin
        if (!r.req) begin
          if (!bus.run) begin
            n.st = S_IDLE;
          end else begin
            n.req = 1'b1;
            n.we = 1'b0;
            n.addr = r.cur + erdma_pkg::DESC_W0;
          end
        end else if (bus.ack) begin
          n.req = 1'b0;
          // a host-owned descriptor is polled again, never written
          if (bus.rdata[erdma_pkg::OWN_BIT]) begin
            n.st = S_RD1;
          end
        end
      end
      S_RD1: begin
        if (!r.req) begin
          n.req = 1'b1;
          n.addr = r.cur + erdma_pkg::DESC_W1;
        end else if (bus.ack) begin
          n.req = 1'b0;
          n.size = bus.rdata[erdma_pkg::SIZE_MSB:0];
          n.ring_end = bus.rdata[erdma_pkg::RING_END_BIT];
          n.st = S_RD2;
        end
      end
      S_RD2: begin
        if (!r.req) begin
          n.req = 1'b1;
          n.addr = r.cur + erdma_pkg::DESC_W2;
        end else if (bus.ack) begin
          n.req = 1'b0;
          n.buf_a = bus.rdata;
          n.st = S_RD3;
        end
      end
      S_RD3: begin
        if (!r.req) begin
          n.req = 1'b1;
          n.addr = r.cur + erdma_pkg::DESC_W3;
        end else if (bus.ack) begin
          n.req = 1'b0;
          n.nxt = bus.rdata;
          n.off = 12'h000;
          if (r.size == 11'h000) begin
            // empty buffer: move on, the frame starts later
            n.cur = r.ring_end ? bus.rx_base : bus.rdata;
            n.st = S_RD0;
          end else begin
            n.st = S_DATA;
          end
        end
      end
      S_DATA: begin
        // only payload words land in the buffer
        if (i_rx_valid) begin
          n.req = 1'b1;
          n.we = 1'b1;
          n.addr = r.buf_a + {20'h0_0000, r.off};
          n.wdata = i_rx_data;
          n.off = r.off + 12'h004; // sizes are whole words
          n.st = S_WRD;
        end
      end
      S_WRD: begin
        if (bus.ack) begin
          n.req = 1'b0;
          n.we = 1'b0;
          if (r.last) begin
            // bad runt: discard and reuse this buffer for the next frame
            if (r.runt && !bus.pass_bad) begin
              n.drop = 1'b1;
              n.off = 12'h000;
              n.st = S_DATA;
            end else begin
              n.st = S_CLOSE;
            end
          end else if (r.off >= {1'b0, r.size}) begin
            n.st = bus.chain_en ? S_CLOSE : S_DRAIN;
          end else begin
            n.st = S_DATA;
          end
        end
      end
      S_DRAIN: begin
        // chaining off: rest of the frame is counted but not stored
        if (i_rx_valid && i_rx_last) begin
          n.st = (i_rx_runt && !bus.pass_bad) ? S_DATA : S_CLOSE;
          n.drop = i_rx_runt && !bus.pass_bad;
          n.off = (i_rx_runt && !bus.pass_bad) ? 12'h000 : r.off;
        end
      end
      S_CLOSE: begin
        if (!r.req) begin
          n.req = 1'b1;
          n.we = 1'b1;
          n.addr = r.cur + erdma_pkg::DESC_W0;
          n.wdata = stat_w;
        end else if (bus.ack) begin
          n.req = 1'b0;
          n.we = 1'b0;
          n.done = r.last;
          n.cur = r.ring_end ? bus.rx_base : r.nxt;
          n.first = r.last; // next buffer opens a new frame or continues
          n.st = S_RD0;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // frame bookkeeping on each accepted stream word
    if (o_rx_ready && i_rx_valid) begin
      n.len = r.len + (i_rx_last ? {13'h0000, i_rx_nbytes} :
        erdma_pkg::FULL_WORD_BYTES);
      n.phy = r.phy | i_rx_phy_err;
      if (i_rx_last) begin
        n.last = 1'b1;
        n.crc = i_rx_crc_err;
        n.runt = i_rx_runt;
        n.mc = i_rx_mcast;
        n.ip_bad = i_rx_ip_err;
        n.tcp_bad = i_rx_tcp_err;
        n.udp_bad = i_rx_udp_err;
        n.ftype = i_rx_type_len > erdma_pkg::TYPE_LEN_MAX;
      end
    end
    // a finished or dropped frame leaves nothing behind
    if (n.drop || (r.st == S_CLOSE && n.st == S_RD0 && r.last)) begin
      n.len = 16'h0000;
      n.last = 1'b0;
      n.phy = 1'b0;
      n.crc = 1'b0;
      n.runt = 1'b0;
      n.mc = 1'b0;
      n.ip_bad = 1'b0;
      n.tcp_bad = 1'b0;
      n.udp_bad = 1'b0;
      n.ftype = 1'b0;
      n.first = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
      r.st <= S_IDLE;
      r.first <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // the switch is stalled whenever no owned buffer is open
  assign o_rx_ready = (r.st == S_DATA) || (r.st == S_DRAIN);
  assign o_frame_done = r.done;
  assign o_frame_dropped = r.drop;
  assign o_busy = r.st != S_IDLE;
  assign bus.req = r.req;
  assign bus.we = r.we;
  assign bus.addr = r.addr;
  assign bus.wdata = r.wdata;
  assign bus.frame_done = r.done;
endmodule : erdma_dev
`default_nettype wire

// ==== erdma_host.sv ====
// host end: descriptor and buffer memory plus software registers
`timescale 1ns/100ps
`default_nettype none
module erdma_host #(
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // software port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // engine side
  erdma_if.host bus
);
  localparam int IW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [2:0] ctrl;
    logic [31:0] rx_base;
    logic [31:0] tx_base;
    logic rx_set;
    logic tx_set;
    logic ack;
    logic [31:0] dma_rd;
    logic [31:0] sw_rd;
    logic [15:0] frames;
  } erdma_host_s;

  erdma_host_s r;
  erdma_host_s n;
  logic sw_mem;
  logic dma_mem;
  logic [IW-1:0] sw_idx;
  logic [IW-1:0] dma_idx;

  // decode both ports
  always_comb begin
    sw_mem = !i_addr[erdma_pkg::MEM_SEL_BIT] && ((i_addr[10:2] >> IW) == 9'h000);
    dma_mem = (bus.addr >> (IW + 2)) == 32'h0000_0000;
    sw_idx = i_addr[IW+1:2];
    dma_idx = bus.addr[IW+1:2];
  end

  // next state; an engine write wins over a software write to one word
  always_comb begin
    n = r;
    n.ack = 1'b0;
    if (i_wr) begin
      if (sw_mem) begin
        n.mem[sw_idx] = i_wdata;
      end
      unique case (i_addr)
        erdma_pkg::REG_CTRL: n.ctrl = i_wdata[2:0];
        erdma_pkg::REG_RX_BASE: begin
          n.rx_base = {i_wdata[31:2], 2'b00}; // forced to a word
          n.rx_set = 1'b1;
        end
        erdma_pkg::REG_TX_BASE: begin
          n.tx_base = {i_wdata[31:2], 2'b00};
          n.tx_set = 1'b1;
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      if (sw_mem) begin
        n.sw_rd = r.mem[sw_idx];
      end else begin
        unique case (i_addr)
          erdma_pkg::REG_CTRL: n.sw_rd = {29'h0000_0000, r.ctrl};
          erdma_pkg::REG_RX_BASE: n.sw_rd = r.rx_base;
          erdma_pkg::REG_TX_BASE: n.sw_rd = r.tx_base;
          erdma_pkg::REG_STATUS: n.sw_rd = {14'h0000, r.tx_set, r.rx_set,
            r.frames};
          default: n.sw_rd = 32'h0000_0000;
        endcase
      end
    end
    // one ack per request; the gap cycle stops a double service
    if (bus.req && !r.ack) begin
      n.ack = 1'b1;
      if (bus.we && dma_mem) begin
        n.mem[dma_idx] = bus.wdata; // owner handed back here
      end
      n.dma_rd = dma_mem ? r.mem[dma_idx] : 32'h0000_0000;
    end
    if (bus.frame_done) begin
      n.frames = r.frames + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
      r.ctrl <= erdma_pkg::CTRL_RESET;
    end else begin
      r <= n;
    end
  end

  // outputs to software and engine
  assign o_rdata = r.sw_rd;
  assign bus.rx_base = r.rx_base;
  assign bus.tx_base = r.tx_base;
  assign bus.bases_ok = r.rx_set && r.tx_set;
  assign bus.run = r.ctrl[erdma_pkg::CTRL_RUN];
  assign bus.chain_en = r.ctrl[erdma_pkg::CTRL_CHAIN];
  assign bus.pass_bad = r.ctrl[erdma_pkg::CTRL_PASS_BAD];
  assign bus.ack = r.ack;
  assign bus.rdata = r.dma_rd;
endmodule : erdma_host
`default_nettype wire

// ==== erdma_if.sv ====
// link between the dma engine and the host memory and configuration end
`timescale 1ns/100ps
`default_nettype none
interface erdma_if;
  // configuration from host software
  logic [31:0] rx_base;
  logic [31:0] tx_base;
  logic bases_ok;
  logic run;
  logic chain_en;
  logic pass_bad;
  // memory access, engine is master
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  // completion event
  logic frame_done;
  modport dev (input rx_base, tx_base, bases_ok, run, chain_en, pass_bad,
    rdata, ack, output req, we, addr, wdata, frame_done);
  modport host (output rx_base, tx_base, bases_ok, run, chain_en, pass_bad,
    rdata, ack, input req, we, addr, wdata, frame_done);
endinterface : erdma_if
`default_nettype wire

// ==== erdma_monitor.sv ====
// concurrent checks on the link between the engine and host ends
`timescale 1ns/100ps
`default_nettype none
module erdma_monitor #(
  // descriptors sit below this address, buffers at or above it
  parameter logic [31:0] DESC_TOP = 32'h0000_0100
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link signals
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic bases_ok,
  input wire logic frame_done
);
  // status write: engine writes word0 of a descriptor
  logic st_wr;
  assign st_wr = req && we && (addr < DESC_TOP) && (addr[3:0] == 4'h0);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // a request stands whole until the host answers
  a_req_hold: assert property (req && !ack |=> req && $stable(addr) &&
    $stable(we) && $stable(wdata)) else $error("request moved before ack");
  a_ack_prompt: assert property ($rose(req) |=> ack)
    else $error("ack late");
  a_req_drop: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_word_align: assert property (req |-> addr[1:0] == 2'h0)
    else $error("unaligned access");
  a_bases_first: assert property (req |-> bases_ok)
    else $error("access before list bases set");
  a_own_return: assert property (st_wr |-> !wdata[31])
    else $error("status write keeps owner flag");
  // summary must be the or of its three causes on the last buffer
  a_errs_or: assert property (st_wr && wdata[29] |->
    wdata[25] == (wdata[16] | wdata[17] | wdata[18]))
    else $error("error summary wrong");
  a_len_last: assert property (st_wr && !wdata[29] |->
    wdata[10:0] == 11'h000) else $error("length on non-last buffer");
  a_done_ack: assert property (frame_done |-> $past(ack) &&
    $past(st_wr) && $past(wdata[29])) else $error("done without last");
endmodule : erdma_monitor
`default_nettype wire

// ==== erdma_pkg.sv ====
// constants shared by the receive descriptor dma engine and its host end
// Notes on behaviour
// - owner flag: set engine owns, engine clears after
// - first flag bit 30; zero-size first skips ahead
// - last flag bit 29 on final buffer
// - checksum errors ip 28, tcp 27, udp 26
// - bit 25 is or of crc, long, runt
// - bit 24 marks multicast destination frames
// - bit 19 marks physical layer receive error
// - bit 18 above 2000 bytes, no truncation
// - runt bit 17; passed only with pass-bad
// - bit 16 marks crc failure
// - bit 15 set when type field above 1500, left clear on runt frames
// - bits 10:0 hold length including crc
// - end-of-ring bit 25 returns to list base
// - buffer size word1 bits 10:0; zero skips
// - host programs buffer sizes in multiples of four
// - host keeps descriptors and buffers word aligned
// - never two frames in one buffer
// - software writes both list bases before use
// - buffers hold payload; status in descriptor
// - chaining across buffers can be switched off
// - word2 buffer pointer, word3 next pointer
// - words 2 and 3 hold aligned 32-bit addresses
package erdma_pkg;
  // descriptor word offsets from the descriptor address
  localparam logic [31:0] DESC_W0 = 32'h0000_0000;
  localparam logic [31:0] DESC_W1 = 32'h0000_0004;
  localparam logic [31:0] DESC_W2 = 32'h0000_0008;
  localparam logic [31:0] DESC_W3 = 32'h0000_000C;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // word0 field positions
  localparam int OWN_BIT = 31;
  localparam int FIRST_BIT = 30;
  localparam int LAST_BIT = 29;
  localparam int IP_SUM_BIT = 28;
  localparam int TCP_SUM_BIT = 27;
  localparam int UDP_SUM_BIT = 26;
  localparam int ERRS_BIT = 25;
  localparam int MCAST_BIT = 24;
  localparam int PHYERR_BIT = 19;
  localparam int LONG_BIT = 18;
  localparam int RUNT_BIT = 17;
  localparam int CRC_BIT = 16;
  localparam int FTYPE_BIT = 15;
  localparam int LEN_MSB = 10;
  // word1 field positions
  localparam int RING_END_BIT = 25;
  localparam int SIZE_MSB = 10;
  // frame limits
  localparam logic [15:0] MAX_FRAME_LEN = 16'h07D0;
  localparam logic [15:0] TYPE_LEN_MAX = 16'h05DC;
  localparam logic [15:0] FULL_WORD_BYTES = 16'h0004;
  // software port map of the host end
  localparam logic [11:0] REG_CTRL = 12'h800;
  localparam logic [11:0] REG_RX_BASE = 12'h804;
  localparam logic [11:0] REG_TX_BASE = 12'h808;
  localparam logic [11:0] REG_STATUS = 12'h80C;
  localparam int MEM_SEL_BIT = 11;
  // control bits: run, chain enable, pass bad frames
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CHAIN = 1;
  localparam int CTRL_PASS_BAD = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;
endpackage : erdma_pkg

// ==== erdma_tb.sv ====
// self-checking bench joining the engine and host ends
`timescale 1ns/100ps
`default_nettype none
module erdma_tb;
  // clock, reset, software port
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [11:0] sw_addr = 12'h000;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  // frame stream; flags are crc, mcast, ip, tcp, udp, runt
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic rx_phy = 1'b0;
  logic [31:0] rx_data = 32'h0000_0000;
  logic [2:0] rx_nb = 3'h0;
  logic [5:0] rx_f = 6'h00;
  logic [15:0] rx_type = 16'h0000;
  logic rx_ready, f_done, f_drop, busy;
  // bench state
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] dbase, v, m;
  // single-word frames: byte count, flags, type field, status word
  logic [56:0] rows [5] = '{{3'h4, 6'h00, 16'h0800, 32'h6000_8004},
    {3'h1, 6'h20, 16'h05DC, 32'h6201_0001},
    {3'h3, 6'h18, 16'h05DD, 32'h7100_8003},
    {3'h2, 6'h06, 16'h0040, 32'h6C00_0002},
    {3'h4, 6'h01, 16'h0000, 32'h6202_0004}};

  erdma_if erdma_if_inst ();
  erdma_dev erdma_dev_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last),
    .i_rx_nbytes(rx_nb), .i_rx_crc_err(rx_f[5]), .i_rx_phy_err(rx_phy),
    .i_rx_runt(rx_f[0]), .i_rx_mcast(rx_f[4]), .i_rx_ip_err(rx_f[3]),
    .i_rx_tcp_err(rx_f[2]), .i_rx_udp_err(rx_f[1]),
    .i_rx_type_len(rx_type), .o_rx_ready(rx_ready), .o_frame_done(f_done),
    .o_frame_dropped(f_drop), .o_busy(busy), .bus(erdma_if_inst));
  erdma_host #(.DEPTH(256)) erdma_host_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(sw_addr), .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd),
    .o_rdata(sw_rdata), .bus(erdma_if_inst));
  erdma_monitor #(.DESC_TOP(32'h0000_0100)) erdma_monitor_inst (
    .i_clk(i_clk), .i_rst(i_rst), .req(erdma_if_inst.req),
    .we(erdma_if_inst.we), .addr(erdma_if_inst.addr),
    .wdata(erdma_if_inst.wdata), .ack(erdma_if_inst.ack),
    .bases_ok(erdma_if_inst.bases_ok),
    .frame_done(erdma_if_inst.frame_done));

  // 20 MHz clock and a cycle ceiling well above the run length
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask : chk

  // one-cycle strobes; the gap edge keeps a strobe from being set twice
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge i_clk);
    sw_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge i_clk);
    sw_rd <= 1'b0;
    @(negedge i_clk);
    v = sw_rdata;
    chk(v, e);
  endtask : rchk

  // a word is held until ready is seen high ahead of the taking edge
  task automatic send(input int n, input logic [2:0] nb,
    input logic [5:0] f, input logic [15:0] t, input int pe);
    int k;
    @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= dbase + 32'(i);
      rx_last <= (i == n - 1);
      rx_nb <= nb;
      rx_f <= f;
      rx_type <= t;
      rx_phy <= (i == pe);
      k = 0;
      do begin
        @(negedge i_clk);
        k++;
      end while (rx_ready !== 1'b1 && k < 500);
      @(posedge i_clk);
    end
    rx_valid <= 1'b0;
  endtask : send

  task automatic wait_ev(input logic sel);
    int k;
    k = 0;
    while ((sel ? f_drop : f_done) !== 1'b1 && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    chk({31'h0, sel ? f_drop : f_done}, 32'h0000_0001);
  endtask : wait_ev

  function automatic logic [31:0] expw(input logic [5:0] f,
    input logic [15:0] t, input logic [10:0] n);
    logic [31:0] w;
    w = 32'h6000_0000;
    w[28:26] = f[3:1];
    w[25] = f[5] | f[0];
    w[24] = f[4];
    w[17] = f[0];
    w[16] = f[5];
    w[15] = t > 16'h05DC;
    w[10:0] = n;
    return w;
  endfunction : expw

  // reset, table of frames, then chaining, drop and overlong cases
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk({29'h0, rx_ready, busy, f_done}, 32'h0000_0000);
    rchk(erdma_pkg::REG_CTRL, 32'h0000_0002);
    wr(erdma_pkg::REG_RX_BASE, 32'h0000_0000);
    wr(erdma_pkg::REG_TX_BASE, 32'h0000_0300);
    wr(12'h000, 32'h0000_0000);
    wr(12'h008, 32'h0000_0100);
    wr(12'h00C, 32'h0000_0010);
    wr(12'h004, 32'h0200_0008);
    wr(erdma_pkg::REG_CTRL, 32'h0000_0007);
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    chk({30'h0, rx_ready, busy}, 32'h0000_0001);
    // one descriptor ring: each frame returns the engine to the base
    for (int r = 0; r < 5; r++) begin
      dbase = 32'hA000_0000 | (32'(r) << 16);
      m = 32'hFFFF_FFFF >> (8 * (4 - rows[r][56:54]));
      wr(12'h000, 32'h8000_0000);
      send(1, rows[r][56:54], rows[r][53:48], rows[r][47:32], -1);
      wait_ev(1'b0);
      rchk(12'h000, rows[r][31:0]);
      rchk(12'h100, dbase);
      chk(v & m, dbase & m);
    end
    // zero-size head, then a frame chained over two buffers
    wr(12'h014, 32'h0000_0004);
    wr(12'h018, 32'h0000_0100);
    wr(12'h01C, 32'h0000_0020);
    wr(12'h010, 32'h8000_0000);
    wr(12'h024, 32'h0200_0008);
    wr(12'h028, 32'h0000_0200);
    wr(12'h020, 32'h8000_0000);
    wr(12'h004, 32'h0000_0000);
    wr(12'h000, 32'h8000_0000);
    dbase = 32'hB000_0000;
    send(3, 3'h2, 6'h00, 16'h0000, -1);
    wait_ev(1'b0);
    rchk(12'h010, 32'h4000_0000);
    rchk(12'h020, 32'h2000_000A);
    rchk(12'h000, 32'h8000_0000);
    rchk(12'h200, 32'hB000_0001);
    // runt without pass-bad is dropped and its buffer kept
    wr(erdma_pkg::REG_CTRL, 32'h0000_0003);
    wr(12'h010, 32'h8000_0000);
    send(1, 3'h4, 6'h01, 16'h0000, -1);
    wait_ev(1'b1);
    rchk(12'h010, 32'h8000_0000);
    // chaining off: 2004 bytes, excess discarded, phy error mid-frame
    wr(erdma_pkg::REG_CTRL, 32'h0000_0001);
    dbase = 32'hC000_0000;
    send(501, 3'h4, 6'h00, 16'h0000, 3);
    wait_ev(1'b0);
    rchk(12'h010, expw(6'h00, 16'h0000, 11'h7D4) |
      32'h020C_0000);
    rchk(12'h100, 32'hC000_0000);
    rchk(erdma_pkg::REG_STATUS, 32'h0003_0007);
    rchk(12'hC00, 32'h0000_0000);
    // mid-run reset while the engine polls: everything back to defaults
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk({28'h0, sw_rdata == 32'h0, rx_ready, busy, f_done}, 32'h8);
    rchk(erdma_pkg::REG_STATUS, 32'h0000_0000);
    rchk(erdma_pkg::REG_CTRL, 32'h0000_0002);
    end_sim();
  end
endmodule : erdma_tb
`default_nettype wire
